/* File: inc/gis_defines.svh */
/*
 holds offsets, field positions, reset values and masks of the global interrupt status block.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef GIS_DEFINES_SVH
`define GIS_DEFINES_SVH

`define GIS_OFF_STATUS 12'h004
`define GIS_OFF_MASK 12'h008
`define GIS_STATUS_RESET 32'h0000_0000
`define GIS_MASK_RESET 32'h0000_0000
`define GIS_QUEUE_IND_RESET 4'h0
`define GIS_FLAG_RESET 1'b0
`define GIS_STATUS_IMPL 32'hFF2D_0003
`define GIS_BIT_RX_LSB 28
`define GIS_BIT_TX_LSB 24
`define GIS_BIT_CFG 21
`define GIS_BIT_SSC 19
`define GIS_BIT_LBI 18
`define GIS_BIT_GPP 16
`define GIS_BIT_ARF 1
`define GIS_BIT_ACTION_REQUEST_DONE_OK 0

`endif

/* File: inc/gis_pkg.sv */
/*
 holds the types of the global interrupt status block.
 assumes the defines header is on the include path.
*/
package gis_pkg;
  `include "gis_defines.svh"

  typedef struct packed {
    logic [3:0] rx_queue_event;
    logic [3:0] tx_queue_event;
    logic config_queue_event;
    logic periph_queue_sync_serial_event;
    logic periph_queue_local_bus_event;
    logic periph_queue_gp_port_event;
  } gis_events_type;

  typedef struct packed {
    logic done;
    logic failed;
  } gis_result_type;
endpackage

/* File: hdl/gis_global_status.sv */
/*
 holds the global interrupt status register with an apb slave, mask register and
 one level interrupt output.
 assumes event pulses come from logic on clk, one cycle each.
*/
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "gis_defines.svh"

module gis_global_status
  import gis_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gis_events_type queue_events,
  input wire gis_result_type action_request_result,
  output logic config_vector_push,
  output logic config_vector_failed,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_setup;
  logic rd_access;
  logic hit_status;
  logic hit_mask;
  logic [31:0] clr_vec;
  logic result_seen;

  ////////////////////////////////////////////////////////////////////////////
  // indication fields, one register per queue group
  // kept apart so a clear of one queue never disturbs another
  logic [3:0] rx_ind_q;
  logic [3:0] rx_ind_d;
  logic [3:0] tx_ind_q;
  logic [3:0] tx_ind_d;
  logic cfg_ind_q;
  logic cfg_ind_d;
  logic ssc_ind_q;
  logic ssc_ind_d;
  logic lbi_ind_q;
  logic lbi_ind_d;
  logic gpp_ind_q;
  logic gpp_ind_d;
  logic ar_failed_q;
  logic ar_failed_d;
  logic ar_done_ok_q;
  logic ar_done_ok_d;

  ////////////////////////////////////////////////////////////////////////////
  // assembled words and next values of the registered outputs
  logic [31:0] status_word;
  logic [31:0] status_next;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic irq_d;
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;
  logic push_d;
  logic push_failed_d;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_is_status(input logic [11:0] a);
    return a == `GIS_OFF_STATUS;
  endfunction

  function automatic logic addr_is_mask(input logic [11:0] a);
    return a == `GIS_OFF_MASK;
  endfunction

  function automatic logic addr_is_mapped(input logic [11:0] a);
    return addr_is_status(a) || addr_is_mask(a);
  endfunction

  // set in the same cycle as a clear wins, so no queue event is lost
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  // places the fields at their positions; unused positions stay zero
  function automatic logic [31:0] pack_status(
    input logic [3:0] rx,
    input logic [3:0] tx,
    input logic cfg,
    input logic sync_serial_controller,
    input logic local_bus_interface,
    input logic general_purpose_port,
    input logic action_request_failed,
    input logic arok
  );
    logic [31:0] v;
    v = `GIS_STATUS_RESET;
    v[`GIS_BIT_RX_LSB +: 4] = rx;
    v[`GIS_BIT_TX_LSB +: 4] = tx;
    v[`GIS_BIT_CFG] = cfg;
    v[`GIS_BIT_SSC] = sync_serial_controller;
    v[`GIS_BIT_LBI] = local_bus_interface;
    v[`GIS_BIT_GPP] = general_purpose_port;
    v[`GIS_BIT_ARF] = action_request_failed;
    v[`GIS_BIT_ACTION_REQUEST_DONE_OK] = arok;
    return v & `GIS_STATUS_IMPL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // phase of the current bus cycle
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access = access_phase && pwrite;
  assign rd_setup = setup_phase && !pwrite;
  assign rd_access = access_phase && !pwrite;
  assign hit_status = addr_is_status(paddr);
  assign hit_mask = addr_is_mask(paddr);
  // the write lands in the access cycle, which this slave never stretches
  assign clr_vec = (wr_access && hit_status) ? pwdata : 32'h0000_0000;
  assign result_seen = action_request_result.done | action_request_result.failed;

  ////////////////////////////////////////////////////////////////////////////
  // next values of the indication fields
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rx_ind_d[i] = sticky_next(rx_ind_q[i], queue_events.rx_queue_event[i], clr_vec[`GIS_BIT_RX_LSB + i]);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tx_ind_d[i] = sticky_next(tx_ind_q[i], queue_events.tx_queue_event[i], clr_vec[`GIS_BIT_TX_LSB + i]);
    end
  end

  // a result vector lands in the configuration queue as well
  always_comb begin
    cfg_ind_d = sticky_next(cfg_ind_q, queue_events.config_queue_event | result_seen, clr_vec[`GIS_BIT_CFG]);
  end

  always_comb begin
    ssc_ind_d = sticky_next(ssc_ind_q, queue_events.periph_queue_sync_serial_event, clr_vec[`GIS_BIT_SSC]);
    lbi_ind_d = sticky_next(lbi_ind_q, queue_events.periph_queue_local_bus_event, clr_vec[`GIS_BIT_LBI]);
    gpp_ind_d = sticky_next(gpp_ind_q, queue_events.periph_queue_gp_port_event, clr_vec[`GIS_BIT_GPP]);
  end

  // failure wins when both result strobes come together
  always_comb begin
    ar_failed_d = sticky_next(ar_failed_q, action_request_result.failed, clr_vec[`GIS_BIT_ARF]);
    ar_done_ok_d = sticky_next(ar_done_ok_q, action_request_result.done && !action_request_result.failed,
      clr_vec[`GIS_BIT_ACTION_REQUEST_DONE_OK]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // indication registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_ind_q <= `GIS_QUEUE_IND_RESET;
    end else begin
      rx_ind_q <= rx_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ind_q <= `GIS_QUEUE_IND_RESET;
    end else begin
      tx_ind_q <= tx_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_ind_q <= `GIS_FLAG_RESET;
    end else begin
      cfg_ind_q <= cfg_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ssc_ind_q <= `GIS_FLAG_RESET;
    end else begin
      ssc_ind_q <= ssc_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lbi_ind_q <= `GIS_FLAG_RESET;
    end else begin
      lbi_ind_q <= lbi_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpp_ind_q <= `GIS_FLAG_RESET;
    end else begin
      gpp_ind_q <= gpp_ind_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ar_failed_q <= `GIS_FLAG_RESET;
      ar_done_ok_q <= `GIS_FLAG_RESET;
    end else begin
      ar_failed_q <= ar_failed_d;
      ar_done_ok_q <= ar_done_ok_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assembled status word, current and next
  always_comb begin
    status_word = pack_status(rx_ind_q, tx_ind_q, cfg_ind_q, ssc_ind_q, lbi_ind_q, gpp_ind_q, ar_failed_q,
      ar_done_ok_q);
  end

  always_comb begin
    status_next = pack_status(rx_ind_d, tx_ind_d, cfg_ind_d, ssc_ind_d, lbi_ind_d, gpp_ind_d, ar_failed_d,
      ar_done_ok_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask of the same layout; one means the bit may drive irq
  always_comb begin
    mask_d = mask_q;
    if (wr_access && hit_mask) begin
      mask_d = pwdata & `GIS_STATUS_IMPL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= `GIS_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // taken from the next status: irq rises on the same edge that sets the status bit
  // and falls on the same edge that applies the clearing write; a new mask acts a cycle late
  always_comb begin
    irq_d = |(status_next & mask_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result vector toward the configuration queue
  always_comb begin
    push_d = result_seen;
    push_failed_d = action_request_result.failed;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_vector_push <= 1'b0;
    end else begin
      config_vector_push <= push_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_vector_failed <= 1'b0;
    end else begin
      config_vector_failed <= push_failed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero wait states: the answer always stands in the cycle after setup
  // unmapped offsets answer with an error, read as zero and ignore writes
  always_comb begin
    pready_d = setup_phase;
    pslverr_d = setup_phase && !addr_is_mapped(paddr);
  end

  // read data is taken at setup and only held through the access cycle
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (rd_setup) begin
      case (paddr)
        `GIS_OFF_STATUS: begin
          prdata_d = status_word;
        end
        `GIS_OFF_MASK: begin
          prdata_d = mask_q;
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end else if (rd_access) begin
      prdata_d = prdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

endmodule
`default_nettype wire

/* File: tb/gis_global_status_props.sv */
/* port checker of the status block
 assumes one clock and rst */
`timescale 1ns/1ns
`default_nettype none
module gis_global_status_props
  import gis_pkg::*;
(
  input wire logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, config_vector_push, config_vector_failed,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata, pwdata,
  input wire gis_events_type queue_events,
  input wire gis_result_type action_request_result
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic su = psel && !penable;
  wire logic rd = su && !pwrite && paddr == 12'h004;
  wire logic wr = pready && pwrite && (paddr == 12'h004 || paddr == 12'h008);
  wire logic [7:0] q8 = queue_events[11:4];
  logic [31:0] m_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) m_q <= '0;
    else if (psel && penable && pready && pwrite && paddr == 12'h008) m_q <= pwdata;
  end
  property p_irq_on; |(q8 & m_q[31:24]) |=> irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq late");
  wire logic [5:0] p6 = {queue_events[3], 1'b0, queue_events[2:1], 1'b0, queue_events[0]};
  property p_ans; su |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_err; su && paddr != 12'h004 && paddr != 12'h008 |=> pslverr && prdata == 0; endproperty
  a_err: assert property (p_err) else $error("unmapped");
  property p_zero; pready && !pwrite && paddr == 12'h004 |-> (prdata & 32'h00D2_FFFC) == 0; endproperty
  a_zero: assert property (p_zero) else $error("reserved bit");
  property p_q8; |q8 ##1 rd |=> (prdata[31:24] & $past(q8, 2)) == $past(q8, 2); endproperty
  a_q8: assert property (p_q8) else $error("queue bit");
  property p_p6; |p6 ##1 rd |=> (prdata[21:16] & $past(p6, 2)) == $past(p6, 2); endproperty
  a_p6: assert property (p_p6) else $error("cfg bit");
  property p_push; |action_request_result |=> config_vector_push && config_vector_failed == $past(action_request_result[0]); endproperty
  a_push: assert property (p_push) else $error("push");
  // irq may trail a mask write by a cycle
  property p_hold; irq && !wr && !$past(wr) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq drop");
  property p_idle; !psel |=> !pready && prdata == 0; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  c_irq: cover property (irq ##1 !irq);
  c_fail: cover property (config_vector_push && config_vector_failed);
  c_err: cover property (pslverr);
endmodule
bind gis_global_status gis_global_status_props chk (.*);
`default_nettype wire

/* File: tb/gis_host_model.sv */
/* apb host of the bench
 assumes a slave that raises pready */
`timescale 1ns/1ns
`default_nettype none
module gis_host_model (
  input wire logic clk, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel = 0, penable = 0, pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0
);
  // waits as long as the slave takes; only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (!pready);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_global_interrupt_status.sv */
/* bench: random events, apb traffic, shadow status word
 assumes host model and checker beside it */
`timescale 1ns/1ns
`default_nettype none
module tb_global_interrupt_status;
  import gis_pkg::*;
  logic clk = 0, rst = 1, psel, penable, pwrite, pready, pslverr, irq, e, ev_on = 0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, w, exp_q = 0, msk_q = 0, s = 97;
  gis_events_type ev = '0;
  gis_result_type res = '0;
  int err_count = 0, n_tests = 0;
  gis_global_status dut (.*, .queue_events(ev), .action_request_result(res), .config_vector_push(),
    .config_vector_failed());
  gis_host_model host (.*);
  always #5 clk = ~clk;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] bits(logic [11:0] x, logic [1:0] a);
    return {x[11:4], 2'b00, x[3] | |a, 1'b0, x[2:1], 1'b0, x[0], 14'h0000, a[0], a[1]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic test_done;
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && pwrite && paddr == 12'h004) exp_q &= ~pwdata;
    if (psel && penable && pready && pwrite && paddr == 12'h008) msk_q = pwdata & 32'hFF2D_0003;
    exp_q |= bits(ev, res);
    s = xs(s);
    ev <= ev_on ? s[11:0] & s[27:16] : '0;
    res <= ev_on ? {s[13], s[12] & ~s[13]} : '0;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    host.xfer(0, 12'h004, 0, r, e);
    chk(r, 0);
    host.xfer(0, 12'h00C, 0, r, e);
    chk(r, 0);
    chk(e, 1);
    for (int i = 0; i < 8; i++) begin
      w = xs(s ^ i);
      host.xfer(1, 12'h008, w, r, e);
      ev_on <= 1;
      repeat (4) @(posedge clk);
      // clear everything while events still arrive: set must beat clear
      host.xfer(1, 12'h004, 32'hFFFF_FFFF, r, e);
      ev_on <= 0;
      repeat (3) @(posedge clk);
      host.xfer(0, 12'h004, 0, r, e);
      chk(r, exp_q);
      chk(e, 0);
      chk(irq, |(exp_q & msk_q));
      host.xfer(1, 12'h004, i == 7 ? 32'hFFFF_FFFF : w ^ s, r, e);
      repeat (2) @(posedge clk);
      chk(irq, |(exp_q & msk_q));
    end
    host.xfer(0, 12'h004, 0, r, e);
    chk(r, 0);
    chk(irq, 0);
    test_done;
  end
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
